//--- include/sbit_defs.vh
`ifndef SBIT_DEFS_VH
`define SBIT_DEFS_VH

`define SBIT_CNT_W 16
`define SBIT_CTL_W 16
`define SBIT_CS_BIT 1
`define SBIT_SYNC_BIT 2
`define SBIT_GATE_BIT 6
`define SBIT_ON_BIT 15
`define SBIT_PS_LO 4
`define SBIT_PS_HI 5
`define SBIT_PS_W 8
`define SBIT_PER_RST 16'hffff
`define SBIT_ZERO 16'h0000
`define SBIT_ONE 16'h0001
`define SBIT_PS_1 2'h0
`define SBIT_PS_8 2'h1
`define SBIT_PS_64 2'h2
`define SBIT_PS_256 2'h3
`define SBIT_PSM_1 8'h00
`define SBIT_PSM_8 8'h07
`define SBIT_PSM_64 8'h3f
`define SBIT_PSM_256 8'hff
`define SBIT_PSC_ONE 8'h01
`define SBIT_PSC_ZERO 8'h00
`define SBIT_SYNC_N 3
`define SBIT_BIT_CLR 1'b0
`define SBIT_BIT_SET 1'b1

`endif

//--- rtl/sbit_timer.v
// Notes on behaviour
// - sixteen-bit counter for clock or intervals
// - counts low-power crystal or instruction clock
// - asynchronous mode counts pin edges unsynchronised
// - sync mode resynchronises after the prescaler
// - timer modes count instruction cycle clock
// - counter modes count external pin
// - control bit 1 selects clock source
// - control bit 6 gates internal clock
// - control bit 2 selects synchronous counting
`timescale 1ns/100ps
`include "sbit_defs.vh"

module sbit_timer (
  input wire ref_clk,
  input wire sys_rst,
  input wire clk_en,
  input wire [15:0] timer_control_register,
  input wire [15:0] period_value,
  input wire instruction_cycle_clock,
  input wire external_count_clock_pin,
  input wire gate_input,
  input wire flag_clear,
  output reg [15:0] count_value,
  output reg timer_flag
);

  // widths fixed at the hardware's sizes
  localparam CNT_W = `SBIT_CNT_W;
  localparam PS_W = `SBIT_PS_W;
  localparam SYNC_N = `SBIT_SYNC_N;

  // prescaler mask: low bits that must all be set for one output tick
  function [PS_W-1:0] ps_mask;
    input [1:0] sel;
    begin
      case (sel)
        `SBIT_PS_1: ps_mask = `SBIT_PSM_1;
        `SBIT_PS_8: ps_mask = `SBIT_PSM_8;
        `SBIT_PS_64: ps_mask = `SBIT_PSM_64;
        default: ps_mask = `SBIT_PSM_256;
      endcase
    end
  endfunction

  // external pin mode: pin selected and sync bit at the wanted level
  function ext_mode;
    input cs;
    input sync_bit;
    input want_sync;
    begin
      ext_mode = cs & (sync_bit == want_sync);
    end
  endfunction

  wire enable = timer_control_register[`SBIT_ON_BIT];
  wire clock_source_select = timer_control_register[`SBIT_CS_BIT];
  wire external_sync_select = timer_control_register[`SBIT_SYNC_BIT];
  wire gate_enable = timer_control_register[`SBIT_GATE_BIT];
  wire [1:0] ps_sel = timer_control_register[`SBIT_PS_HI:`SBIT_PS_LO];
  wire [PS_W-1:0] ps_limit = ps_mask(ps_sel);

  // operating modes from the three select bits
  wire mode_timer = ~clock_source_select & ~gate_enable;
  wire mode_gated = ~clock_source_select & gate_enable;
  wire mode_sync = ext_mode(clock_source_select, external_sync_select, `SBIT_BIT_SET);
  wire mode_async = ext_mode(clock_source_select, external_sync_select, `SBIT_BIT_CLR);
  wire mode_pin = mode_sync | mode_async;

  // pin history
  reg pin_q;
  reg pin_d;

  // prescaler and the toggle that crosses the resynchroniser
  reg [PS_W-1:0] ps_q;
  reg [PS_W-1:0] ps_d;
  reg ps_tick_q;
  reg ps_tick_d;

  // next values of the outputs
  reg [CNT_W-1:0] count_d;
  reg flag_d;
  reg src_tick;

  // previous pin level taken directly, nothing ahead of the prescaler
  wire pin_rise = external_count_clock_pin & ~pin_q;

  // count source per mode
  always @* begin
    src_tick = `SBIT_BIT_CLR;
    if (mode_timer) begin
      src_tick = instruction_cycle_clock;
    end else if (mode_gated) begin
      src_tick = instruction_cycle_clock & gate_input;
    end else if (mode_pin) begin
      src_tick = pin_rise;
    end
  end

  wire ps_wrap = ((ps_q & ps_limit) == ps_limit);
  wire ps_out = enable & src_tick & ps_wrap;

  // sync mode: prescaler toggle retimed through a flop chain
  wire [SYNC_N:0] sync_chain;
  genvar gi;

  assign sync_chain[0] = ps_tick_q;

  generate
    for (gi = 0; gi < SYNC_N; gi = gi + 1) begin : g_sync
      reg stage_q;
      always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          stage_q <= `SBIT_BIT_CLR;
        end else if (clk_en) begin
          stage_q <= sync_chain[gi];
        end
      end
      assign sync_chain[gi + 1] = stage_q;
    end
  endgenerate

  // a toggle seen between the last two stages is one prescaler output
  wire sync_last = sync_chain[SYNC_N];
  wire sync_prev = sync_chain[SYNC_N - 1];
  wire sync_tick = sync_last ^ sync_prev;

  // count enable after mode selection
  wire cnt_tick = mode_sync ? sync_tick : ps_out;
  wire cnt_step = enable & cnt_tick;
  wire period_hit = (count_value == period_value);
  wire wrap_now = cnt_step & period_hit;

  always @* begin
    pin_d = external_count_clock_pin;
  end

  // prescaler, held clear while the timer is off
  always @* begin
    ps_d = ps_q;
    if (!enable) begin
      ps_d = `SBIT_PSC_ZERO;
    end else if (src_tick) begin
      if (ps_wrap) begin
        ps_d = `SBIT_PSC_ZERO;
      end else begin
        ps_d = ps_q + `SBIT_PSC_ONE;
      end
    end
  end

  // in sync mode only, toggle carries each prescaler output into the chain
  always @* begin
    ps_tick_d = ps_tick_q;
    if (ps_out & mode_sync) begin
      ps_tick_d = ~ps_tick_q;
    end
  end

  // count register: wraps to zero on the tick after a period match
  always @* begin
    count_d = count_value;
    if (wrap_now) begin
      count_d = `SBIT_ZERO;
    end else if (cnt_step) begin
      count_d = count_value + `SBIT_ONE;
    end
  end

  // set wins over clear
  always @* begin
    flag_d = timer_flag;
    if (wrap_now) begin
      flag_d = `SBIT_BIT_SET;
    end else if (flag_clear) begin
      flag_d = `SBIT_BIT_CLR;
    end
  end

  // registers; all hold while clk_en is low
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_q <= `SBIT_BIT_CLR;
    end else if (clk_en) begin
      pin_q <= pin_d;
    end
  end

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ps_q <= `SBIT_PSC_ZERO;
    end else if (clk_en) begin
      ps_q <= ps_d;
    end
  end

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ps_tick_q <= `SBIT_BIT_CLR;
    end else if (clk_en) begin
      ps_tick_q <= ps_tick_d;
    end
  end

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_value <= `SBIT_ZERO;
    end else if (clk_en) begin
      count_value <= count_d;
    end
  end

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_flag <= `SBIT_BIT_CLR;
    end else if (clk_en) begin
      timer_flag <= flag_d;
    end
  end

endmodule

//--- tb/sbit_ext_osc.sv
`timescale 1ns/100ps
module sbit_ext_osc (
  input wire ref_clk,
  input wire run,
  output logic pin
);
  initial pin = 1'b0;
  // toggles in bursts, rests low between them
  always @(negedge ref_clk) pin <= run & ~pin;
endmodule

//--- tb/sbit_timer_asserts.sv
`timescale 1ns/100ps
module sbit_timer_asserts (
  input wire ref_clk,
  input wire sys_rst,
  input wire clk_en,
  input wire [15:0] timer_control_register,
  input wire [15:0] period_value,
  input wire instruction_cycle_clock,
  input wire external_count_clock_pin,
  input wire gate_input,
  input wire flag_clear,
  input wire [15:0] count_value,
  input wire timer_flag
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire [15:0] c = timer_control_register;
  wire [15:0] q = count_value;
  wire on = clk_en & c[15];
  wire tm = on & ~|c[5:1];
  wire tk = tm & instruction_cycle_clock & (~c[6] | gate_input);
  wire ex = on & c[1] & ~|c[5:4];
  a_cnt_step: assert property (tk && q != period_value |=> q == $past(q) + 16'h0001)
    else $error("step");
  a_per_wrap: assert property (tk && q == period_value |=> q == 16'h0000 && timer_flag)
    else $error("wrap");
  a_gate_low: assert property (tm && c[6] && !gate_input |=> $stable(q)) else $error("gate");
  a_pin_ignored: assert property (tm && !instruction_cycle_clock |=> $stable(q))
    else $error("pin");
  a_ext_quiet: assert property ((ex && !external_count_clock_pin)[*8] |-> $stable(q))
    else $error("quiet");
  a_async_fast: assert property (ex && !c[2] && $rose(external_count_clock_pin)
    |-> ##[1:2] $changed(q)) else $error("async");
  a_sync_late: assert property (ex && c[2] && $rose(external_count_clock_pin)
    |-> ##[1:6] $changed(q)) else $error("sync");
  a_flag_hold: assert property (timer_flag && !flag_clear |=> timer_flag) else $error("flag");
  a_freeze_hold: assert property (!clk_en |=> $stable(q) && $stable(timer_flag))
    else $error("freeze");
endmodule

//--- tb/tb_sbit_timer.sv
`timescale 1ns/100ps
module tb_sbit_timer;
  logic ref_clk = 0, sys_rst = 1, ic = 0, gate = 0, run = 0, clr = 0, ce = 1, pin;
  logic [15:0] ctl = 16'h0000, per = 16'h0004;
  wire [15:0] cnt;
  wire flg;
  int mismatches = 0, compares = 0;
  always #4 ref_clk = ~ref_clk;
  sbit_ext_osc sbit_ext_osc_inst (.ref_clk(ref_clk), .run(run), .pin(pin));
  sbit_timer sbit_timer_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(ce),
    .timer_control_register(ctl), .period_value(per), .instruction_cycle_clock(ic),
    .external_count_clock_pin(pin), .gate_input(gate), .flag_clear(clr),
    .count_value(cnt), .timer_flag(flg));
  task chk(input [15:0] got, input [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task start(input [15:0] c);
    sys_rst = 1;
    gate = 0;
    @(negedge ref_clk);
    sys_rst = 0;
    ctl = c;
  endtask
  task ticks(input int n);
    repeat (n) begin
      ic = 1;
      @(negedge ref_clk);
      ic = 0;
      @(negedge ref_clk);
    end
  endtask
  task t_timer;
    start(16'h8000);
    ticks(7);
    chk(cnt, 16'h0002);
    chk({15'h0000, flg}, 16'h0001);
    clr = 1;
    @(negedge ref_clk);
    clr = 0;
    chk({15'h0000, flg}, 16'h0000);
  endtask
  task t_gated;
    start(16'h8040);
    ticks(3);
    chk(cnt, 16'h0000);
    gate = 1;
    ticks(3);
    chk(cnt, 16'h0003);
  endtask
  task t_freeze;
    start(16'h8000);
    ticks(2);
    ce = 0;
    ticks(3);
    chk(cnt, 16'h0002);
    ce = 1;
    ticks(1);
    chk(cnt, 16'h0003);
  endtask
  task t_prescale;
    start(16'h8014);
    ticks(7);
    chk(cnt, 16'h0000);
    ticks(1);
    chk(cnt, 16'h0001);
  endtask
  task t_ext(input [15:0] c);
    start(c);
    ticks(2);
    run <= 1;
    repeat (6) @(negedge ref_clk);
    run <= 0;
    repeat (8) @(negedge ref_clk);
    chk(cnt, 16'h0003);
  endtask
  task finish_test;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #20000;
    mismatches++;
    finish_test;
  end
  initial begin
    repeat (2) @(negedge ref_clk);
    t_timer;
    t_gated;
    t_freeze;
    t_prescale;
    t_ext(16'h8042);
    t_ext(16'h8046);
    finish_test;
  end
endmodule
bind sbit_timer sbit_timer_asserts sbit_timer_asserts_inst (.ref_clk, .sys_rst, .clk_en,
  .timer_control_register, .period_value, .instruction_cycle_clock,
  .external_count_clock_pin, .gate_input, .flag_clear, .count_value, .timer_flag);
